// file: rtl/mdfp_fault_protect.sv
// Fault protection, output gating and duty ramp of the bridge driver
`timescale 1ns/1ps
`include "mdfp_regs.svh"
module mdfp_fault_protect
  import mdfp_pkg::*;
#(
  parameter int unsigned RESTART_TB_CYC = `MDFP_TB_DEF_CYC,
  parameter int unsigned RAMP_TB_CYC    = `MDFP_TB_DEF_CYC,
  parameter int unsigned UV_WAIT_CYC    = `MDFP_UV_WAIT_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire logic                   currentLimitFlag,
  input  wire logic [5:0]             overcurrentFlags,
  input  wire logic                   thermalFlag,
  input  wire logic                   motorSupplyUvFlag,
  input  wire logic                   regulatorUvFlag,
  input  wire logic                   pwmOn,
  input  wire logic [5:0]             gateDemand,
  input  wire logic [7:0]             speedCommandDuty,
  output logic      [5:0]             gateOut,
  output logic      [5:0]             gateOe,
  output logic      [7:0]             dutyOut,
  output logic                        overcurrentShutdown,
  output logic                        thermalShutdown,
  output logic                        supplyUndervoltageLockout,
  output logic                        driveEnable
);

  // Two-stage synchronisers for every asynchronous input
  logic [23:0] sync1Q;
  logic [23:0] sync2Q;
  wire  [23:0] rawIn = {speedCommandDuty, gateDemand, pwmOn, regulatorUvFlag, motorSupplyUvFlag,
                        thermalFlag, overcurrentFlags};
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1Q <= 24'h000000;
      sync2Q <= 24'h000000;
    end else begin
      sync1Q <= rawIn;
      sync2Q <= sync1Q;
    end
  end
  logic limSync1Q;
  logic limSync2Q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      limSync1Q <= 1'b0;
      limSync2Q <= 1'b0;
    end else begin
      limSync1Q <= currentLimitFlag;
      limSync2Q <= limSync1Q;
    end
  end

  wire [5:0] ocS     = sync2Q[5:0];
  wire       tsdS    = sync2Q[6];
  wire       uvS     = sync2Q[7] | sync2Q[8];
  wire       pwmS    = sync2Q[9];
  wire [5:0] demandS = sync2Q[15:10];
  wire [7:0] speedCommandDutyS = sync2Q[23:16];

  localparam logic [8:0] MASK_CYC = 9'(`MDFP_MASK_CYC);

  function automatic logic [8:0] sat_inc(input logic [8:0] v, input logic run);
    sat_inc = !run ? 9'h000 : (v == MASK_CYC) ? v : v + 9'h001;
  endfunction : sat_inc

  // Persistence counters for the two comparator masks
  logic [8:0] limCntQ;
  logic [8:0] ocCntQ;
  wire        ocAny    = |ocS;
  wire        limValid = limSync2Q && (limCntQ == MASK_CYC);
  wire        ocValid  = ocAny && (ocCntQ == MASK_CYC);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      limCntQ <= 9'h000;
      ocCntQ  <= 9'h000;
    end else begin
      limCntQ <= uvS ? 9'h000 : sat_inc(limCntQ, limSync2Q);
      ocCntQ  <= uvS ? 9'h000 : sat_inc(ocCntQ, ocAny);
    end
  end

  // High-side blanking holds until the next PWM on edge
  logic pwmPrevQ;
  logic hsOffQ;
  wire  pwmRise = pwmS && !pwmPrevQ;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pwmPrevQ <= 1'b0;
      hsOffQ   <= 1'b0;
    end else begin
      pwmPrevQ <= pwmS;
      if (uvS) begin
        hsOffQ <= 1'b0;
      end else if (limValid) begin
        hsOffQ <= 1'b1;
      end else if (pwmRise) begin
        hsOffQ <= 1'b0;
      end
    end
  end

  // Timebase divider: 31.5 periods equals 63 half periods
  localparam int unsigned HALF_CYC = (RESTART_TB_CYC / 2 < 1) ? 1 : RESTART_TB_CYC / 2;
  localparam int unsigned RHALF    = (RAMP_TB_CYC / 2 < 1) ? 1 : RAMP_TB_CYC / 2;
  localparam logic [6:0]  STEPS    = 7'(`MDFP_STEPS_HALF);

  mdfp_state_e stateQ;
  mdfp_state_e stateD;
  logic [31:0] tbCntQ;
  logic [6:0]  halfCntQ;
  logic        ocLatchQ;
  logic        tsdLatchQ;
  wire         tbTick = (tbCntQ == 32'(HALF_CYC - 1));
  wire         uvDone = (tbCntQ == 32'(UV_WAIT_CYC - 1));
  wire         causeActive = ocValid | tsdS;
  wire         restartDone = tbTick && (halfCntQ == STEPS - 7'h01);

  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      MDFP_RUN:     if (causeActive) stateD = MDFP_FAULT;
      MDFP_FAULT:   if (!ocAny && !tsdS) stateD = MDFP_RESTART;
      MDFP_RESTART: begin
        if (causeActive) stateD = MDFP_FAULT;
        else if (restartDone) stateD = MDFP_RUN;
      end
      MDFP_UVWAIT:  if (uvDone) stateD = MDFP_RUN;
    endcase
    if (uvS) stateD = MDFP_UVWAIT;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stateQ    <= MDFP_UVWAIT;
      tbCntQ    <= 32'h00000000;
      halfCntQ  <= 7'h00;
      ocLatchQ  <= 1'b0;
      tsdLatchQ <= 1'b0;
    end else begin
      stateQ <= stateD;
      if (stateD != stateQ || uvS) begin
        tbCntQ   <= 32'h00000000;
        halfCntQ <= 7'h00;
      end else if (stateQ == MDFP_UVWAIT) begin
        tbCntQ <= tbCntQ + 32'h00000001;
      end else if (stateQ == MDFP_RESTART) begin
        tbCntQ <= tbTick ? 32'h00000000 : tbCntQ + 32'h00000001;
        if (tbTick) halfCntQ <= halfCntQ + 7'h01;
      end
      ocLatchQ  <= uvS ? 1'b0 : ocValid | (ocLatchQ && stateQ != MDFP_RUN && stateD != MDFP_RUN);
      tsdLatchQ <= uvS ? 1'b0 : tsdS | (tsdLatchQ && stateQ != MDFP_RUN && stateD != MDFP_RUN);
    end
  end

  // Duty ramp: one LSB step per ramp tick while command is above output
  localparam logic [31:0] RAMP_STEP = 32'((RHALF * `MDFP_STEPS_HALF) / 256 < 1 ? 1 :
                                          (RHALF * `MDFP_STEPS_HALF) / 256);
  logic [31:0] rampCntQ;
  logic [7:0]  dutyQ;
  wire         rampTick = (rampCntQ == RAMP_STEP - 32'h00000001);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rampCntQ <= 32'h00000000;
      dutyQ    <= 8'h00;
    end else if (uvS || stateQ != MDFP_RUN) begin
      rampCntQ <= 32'h00000000;
      dutyQ    <= 8'h00;
    end else if (speedCommandDutyS <= dutyQ) begin
      rampCntQ <= 32'h00000000;
      dutyQ    <= speedCommandDutyS;
    end else begin
      rampCntQ <= rampTick ? 32'h00000000 : rampCntQ + 32'h00000001;
      if (rampTick) dutyQ <= dutyQ + 8'h01;
    end
  end

  // Output gating; outputs registered so shutdown reaches pins one cycle later
  wire       runOk   = (stateQ == MDFP_RUN) && !causeActive && !uvS;
  wire [5:0] hsMask  = hsOffQ ? 6'(`MDFP_HS_MASK) : 6'h00;
  wire [5:0] gateEn  = runOk ? ~hsMask : 6'h00;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gateOut                   <= 6'h00;
      gateOe                    <= 6'h00;
      dutyOut                   <= 8'h00;
      overcurrentShutdown       <= 1'b0;
      thermalShutdown           <= 1'b0;
      supplyUndervoltageLockout <= 1'b1;
      driveEnable               <= 1'b0;
    end else begin
      gateOut                   <= demandS & gateEn;
      gateOe                    <= gateEn;
      dutyOut                   <= dutyQ;
      overcurrentShutdown       <= ocLatchQ;
      thermalShutdown           <= tsdLatchQ;
      supplyUndervoltageLockout <= uvS;
      driveEnable               <= runOk;
    end
  end

endmodule : mdfp_fault_protect

// file: rtl/mdfp_pkg.sv
// Types for the motor driver fault protection block
package mdfp_pkg;
  typedef enum logic [1:0] {
    MDFP_RUN     = 2'b00,
    MDFP_FAULT   = 2'b01,
    MDFP_RESTART = 2'b10,
    MDFP_UVWAIT  = 2'b11
  } mdfp_state_e;
  typedef logic [7:0] mdfp_duty_t;
endpackage : mdfp_pkg

// file: rtl/mdfp_regs.svh
// Timing constants and field positions for the motor driver fault protection block
`ifndef MDFP_REGS_SVH
`define MDFP_REGS_SVH
`define MDFP_CLK_MHZ          100
`define MDFP_MASK_TIME_NS     3000
`define MDFP_MASK_CYC         ((`MDFP_MASK_TIME_NS * `MDFP_CLK_MHZ + 999) / 1000)
`define MDFP_STEPS_HALF       63
`define MDFP_TB_DEF_CYC       1000
`define MDFP_UV_WAIT_MS       100
`define MDFP_UV_WAIT_CYC      (`MDFP_UV_WAIT_MS * `MDFP_CLK_MHZ * 1000)
`define MDFP_DUTY_W           8
`define MDFP_PH_N             6
`define MDFP_HS_MASK          6'h15
`endif

// file: sim/mdfp_bridge_model.sv
// Behavioural bridge and fault comparator model
`timescale 1ns/1ps
module mdfp_bridge_model (
  input  wire logic [5:0] gateOut,
  input  wire logic [5:0] gateOe,
  input  wire logic [5:0] shortLeg,
  input  wire logic       heavyLoad,
  output logic      [5:0] overcurrentFlags,
  output logic            currentLimitFlag
);
  // A shorted leg only draws current while it conducts, so a shutdown clears its flag
  assign overcurrentFlags = shortLeg & gateOut & gateOe;
  assign currentLimitFlag = heavyLoad & (|(gateOut & gateOe & 6'h15));
endmodule : mdfp_bridge_model

// file: sim/mdfp_fault_protect_chk.sv
// Port checker for the fault protection block
`timescale 1ns/1ps
module mdfp_fault_protect_chk
  import mdfp_pkg::*;
#(
  parameter int unsigned RESTART_TB_CYC = 1000
) (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic [5:0] overcurrentFlags,
  input wire logic       thermalFlag,
  input wire logic       motorSupplyUvFlag,
  input wire logic       regulatorUvFlag,
  input wire logic [5:0] gateOe,
  input wire logic [7:0] dutyOut,
  input wire logic       overcurrentShutdown,
  input wire logic       thermalShutdown,
  input wire logic       supplyUndervoltageLockout,
  input wire logic       driveEnable
);
  localparam int unsigned RESTART_CYC = 63 * (RESTART_TB_CYC / 2);
  logic [15:0] ocRun_q, clrRun_q, uvRun_q;
  function automatic logic [15:0] inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : inc
  // Run lengths counted at the pins, so sync latency adds margin to every check but a_restart_max, where it uses up part of the 70
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ocRun_q  <= 16'h0000;
      clrRun_q <= 16'h0000;
      uvRun_q  <= 16'h0000;
    end else begin
      ocRun_q  <= (|overcurrentFlags) ? inc(ocRun_q) : 16'h0000;
      clrRun_q <= (thermalFlag || (|overcurrentFlags)) ? 16'h0000 : inc(clrRun_q);
      uvRun_q  <= (motorSupplyUvFlag || regulatorUvFlag) ? 16'h0000 : inc(uvRun_q);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_msuv_hiz: assert property (motorSupplyUvFlag [*4] |-> gateOe == 6'h00 && !driveEnable)
    else $error("outputs driven during supply lockout");
  a_reguv_lock: assert property (regulatorUvFlag [*4] |-> supplyUndervoltageLockout && gateOe == 6'h00)
    else $error("regulator lockout not applied");
  a_therm_hiz: assert property (thermalFlag [*4] |-> gateOe == 6'h00 && !driveEnable)
    else $error("outputs driven while over temperature");
  a_oc_mask: assert property ($rose(overcurrentShutdown) |-> $past(ocRun_q, 3) >= 16'h0129)
    else $error("over-current shutdown before mask time");
  a_oc_hiz: assert property ($rose(overcurrentShutdown) |-> ##[0:1] gateOe == 6'h00)
    else $error("over-current shutdown left outputs driven");
  a_restart_min: assert property ($rose(driveEnable) && $past(overcurrentShutdown || thermalShutdown)
    |-> clrRun_q >= RESTART_CYC)
    else $error("drive resumed before restart interval");
  a_restart_max: assert property (clrRun_q == RESTART_CYC + 70 |-> !overcurrentShutdown && !thermalShutdown)
    else $error("shutdown held past restart interval");
  a_uv_wait: assert property ($rose(driveEnable) |-> uvRun_q >= 16'h0064)
    else $error("drive resumed too soon after lockout");
  a_duty_ramp: assert property (dutyOut > $past(dutyOut) |-> dutyOut == $past(dutyOut) + 8'h01
    ##1 dutyOut <= $past(dutyOut))
    else $error("duty rose faster than one step");
  cover property ($rose(overcurrentShutdown));
  cover property ($rose(thermalShutdown));
  cover property ($rose(driveEnable) && $past(overcurrentShutdown));
endmodule : mdfp_fault_protect_chk
bind mdfp_fault_protect mdfp_fault_protect_chk #(.RESTART_TB_CYC(RESTART_TB_CYC)) i_chk (.*);

// file: sim/testbench.sv
// Self-checking bench for the fault protection block
`timescale 1ns/1ps
module testbench;
  import mdfp_pkg::*;
  logic       mclk = 1'b0, rstn = 1'b0, thermalFlag = 1'b0, pwmOn = 1'b0, heavyLoad = 1'b0;
  logic       motorSupplyUvFlag = 1'b0, regulatorUvFlag = 1'b0;
  logic [5:0] gateDemand = 6'h21, shortLeg = 6'h00;
  mdfp_duty_t speedCommandDuty = 8'h00;
  logic [5:0] overcurrentFlags, gateOut, gateOe;
  mdfp_duty_t dutyOut;
  logic       currentLimitFlag, overcurrentShutdown, thermalShutdown, supplyUndervoltageLockout, driveEnable;
  int         fail_count = 0, tests_run = 0, cycles = 0;
  // Short timebases: restart 630 cycles, lockout wait 100 cycles
  mdfp_fault_protect #(.RESTART_TB_CYC(20), .RAMP_TB_CYC(20), .UV_WAIT_CYC(100)) i_mdfp_fault_protect (.*);
  mdfp_bridge_model i_mdfp_bridge_model (.*);
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 12000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic wt(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wt
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_run(int lim);
    int n;
    n = 0;
    while (driveEnable !== 1'b1 && n < lim) begin
      wt(1);
      n++;
    end
    chk("driveEnable", 8'h01, {7'h00, driveEnable});
  endtask : wait_run
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic t_uv();
    wt(60);
    chk("driveEnable", 8'h00, {7'h00, driveEnable});
    wait_run(80);
    for (int i = 0; i < 2; i++) begin
      motorSupplyUvFlag = (i == 0);
      regulatorUvFlag = (i == 1);
      wt(8);
      chk("gateOe", 8'h00, {2'b00, gateOe});
      chk("lockout", 8'h01, {7'h00, supplyUndervoltageLockout});
      motorSupplyUvFlag = 1'b0;
      regulatorUvFlag = 1'b0;
      wt(60);
      chk("driveEnable", 8'h00, {7'h00, driveEnable});
      wait_run(80);
    end
  endtask : t_uv
  task automatic t_ramp();
    speedCommandDuty = 8'h40;
    wt(40);
    chk("dutyRamping", 8'h01, {7'h00, dutyOut < 8'h40});
    wt(200);
    chk("dutyOut", 8'h40, dutyOut);
    speedCommandDuty = 8'h10;
    wt(6);
    chk("dutyOut", 8'h10, dutyOut);
  endtask : t_ramp
  task automatic t_limit();
    heavyLoad = 1'b1;
    wt(200);
    heavyLoad = 1'b0;
    wt(5);
    chk("gateOut", 8'h21, {2'b00, gateOut});
    heavyLoad = 1'b1;
    wt(320);
    heavyLoad = 1'b0;
    wt(10);
    chk("gateOut", 8'h20, {2'b00, gateOut});
    pwmOn = 1'b1;
    wt(5);
    chk("gateOut", 8'h21, {2'b00, gateOut});
    pwmOn = 1'b0;
  endtask : t_limit
  task automatic t_oc();
    shortLeg = 6'h20;
    wt(200);
    shortLeg = 6'h00;
    wt(5);
    chk("ocShutdown", 8'h00, {7'h00, overcurrentShutdown});
    shortLeg = 6'h20;
    wt(320);
    chk("gateOe", 8'h00, {2'b00, gateOe});
    chk("ocShutdown", 8'h01, {7'h00, overcurrentShutdown});
    shortLeg = 6'h00;
    wt(580);
    chk("driveEnable", 8'h00, {7'h00, driveEnable});
    wait_run(100);
  endtask : t_oc
  task automatic t_therm();
    thermalFlag = 1'b1;
    wt(8);
    chk("gateOe", 8'h00, {2'b00, gateOe});
    chk("thermalShutdown", 8'h01, {7'h00, thermalShutdown});
    wt(100);
    thermalFlag = 1'b0;
    wt(600);
    chk("driveEnable", 8'h00, {7'h00, driveEnable});
    wait_run(100);
  endtask : t_therm
  initial begin
    wt(20);
    rstn = 1'b1;
    t_uv();
    t_ramp();
    t_limit();
    t_oc();
    t_therm();
    end_sim();
  end
endmodule : testbench
